// *** wbcsr_pkg.sv ***
// Constants, field layouts and carriers for the Wishbone CSR access port.
// Assumes a 32-bit Wishbone slave on the core clock; link logic sits behind it.
// Operation
// RL1: Write data lanes: N+2 upper, lower, N upper, lower
// RL2: Config reads return byte-swapped lanes
// RL3: CSR reads keep write lane order
// RL4: Bits within each lane run 7 down 0
// RL5: Low window maps whole config space, 32-bit
// RL6: Vendor/power DLLP receive flags, clear on write
// RL7: Capture vendor payload and power type on receive
// RL8: Transmit request bits self-clear after send
// RL9: Transmit uses held payload and type code
// RL10: Read-only per-lane lane-sync status bits 23:20
// RL11: Connection status 19:16, clear on write
// RL12: Receive electrical idle status bits 15:12
// RL13: Link training state code in 11:7
// RL14: Data-link state bits in 6:3
// RL15: Control bit 17 enables packet debug bypass
// RL16: Bits 15:13 force lane, idle, connection status
// RL17: Bit 12 scrambler off, 11 TS disable bit
// RL18: Bits 10:0 direct link training, bit 3 reserved
// RL19: Bits 21:18 loopback per lane, 16 beacon
// RL20: Flow-control update frequency header and data fields
// RL21: Link config access wins, Wishbone ack delayed
// RL22: Reserved bits read zero, ignore writes
// RL23: Control bits reset to zero
package wbcsr_pkg;
    localparam logic [12:0] WBCSR_CFG_LAST = 13'h0FFF;
    localparam logic [12:0] WBCSR_RX_DLLP = 13'h1000;
    localparam logic [12:0] WBCSR_TX_DLLP = 13'h1004;
    localparam logic [12:0] WBCSR_STATUS = 13'h1008;
    localparam logic [12:0] WBCSR_CONTROL = 13'h100C;
    localparam logic [12:0] WBCSR_TIMERS = 13'h1010;
    localparam logic [12:0] WBCSR_UPD_POST = 13'h1014;
    localparam logic [12:0] WBCSR_UPD_NPOST = 13'h1018;
    localparam logic [12:0] WBCSR_UPD_CPL = 13'h101C;
    localparam logic [12:0] WBCSR_FC_TIMER = 13'h1020;
    localparam logic [12:0] WBCSR_LINK_NUM = 13'h1024;
    // Field positions
    localparam int WBCSR_RX_VEND_BIT = 31;
    localparam int WBCSR_RX_PWR_BIT = 30;
    localparam int WBCSR_TX_VEND_BIT = 31;
    localparam int WBCSR_TX_PWR_BIT = 30;
    // Write masks; reserved bits stay zero
    localparam logic [31:0] WBCSR_TX_MASK = 32'hC7FFFFFF;
    localparam logic [31:0] WBCSR_CTRL_MASK = 32'h003FFFF7;
    localparam logic [31:0] WBCSR_TIMER_MASK = 32'h3FFF7FFF;
    localparam logic [31:0] WBCSR_UPD_MASK = 32'h0003FFFF;
    localparam logic [31:0] WBCSR_FCT_MASK = 32'h00000FFF;
    localparam logic [31:0] WBCSR_LNUM_MASK = 32'h000000FF;
    // Reset values
    localparam logic [31:0] WBCSR_ZERO_RST = 32'h00000000;
    localparam logic [31:0] WBCSR_TIMER_RST = 32'h00000000;
    localparam logic [31:0] WBCSR_UPD_RST = 32'h00000000;
    localparam logic [31:0] WBCSR_FCT_RST = 32'h00000000;

    typedef enum logic [1:0] {
        WBCSR_IDLE = 2'b00,
        WBCSR_WAIT = 2'b01,
        WBCSR_ACK = 2'b11
    } wbcsr_state_e;

    // Received DLLP event from the link layer
    typedef struct packed {
        logic vend_valid;
        logic [25:0] vend_data;
        logic pwr_valid;
        logic [2:0] pwr_type;
    } wbcsr_rx_dllp_s;

    // Status from PHY and data-link layer
    typedef struct packed {
        logic [3:0] lane_sync_state;
        logic [3:0] conn_set;
        logic [3:0] rx_elec_idle;
        logic [4:0] ltssm_state;
        logic [3:0] dl_state;
    } wbcsr_phy_stat_s;

    // Control towards PHY and link training
    typedef struct packed {
        logic [3:0] goto_loopback;
        logic debug_bypass;
        logic send_beacon;
        logic force_lane_sync;
        logic force_elec_idle;
        logic force_conn;
        logic scramble_off;
        logic ts_no_scramble;
        logic [10:0] train_goto;
    } wbcsr_ctrl_s;

    function automatic logic [31:0] wbcsr_swap(input logic [31:0] w);
        wbcsr_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
endpackage

// *** wbcsr_lanes.sv ***
// Per-lane status stage: applies force overrides and holds sticky connect bits.
// Assumes PHY status inputs are synchronous to the core clock.
`timescale 1ns/1ps
module wbcsr_lanes
    import wbcsr_pkg::*;
#(
    parameter int LANES = 1
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Controls
    input wire logic force_sync_i,
    input wire logic force_idle_i,
    input wire logic force_conn_i,
    input wire logic conn_clear_i,
    // Raw status
    input wire logic [3:0] sync_i,
    input wire logic [3:0] idle_i,
    input wire logic [3:0] conn_i,
    // Effective status
    output logic [3:0] sync_o,
    output logic [3:0] idle_o,
    output logic [3:0] conn_o
);
    logic [3:0] used;
    logic [3:0] conn_reg;
    logic [3:0] conn_next;

    // Unbuilt lanes read as zero
    assign used = 4'(({4'h0, 4'hF} << LANES) >> 4);
    assign sync_o = (force_sync_i ? 4'hF : sync_i) & used; // RL16 RL10
    assign idle_o = (force_idle_i ? 4'hF : idle_i) & used; // RL16 RL12
    assign conn_o = (conn_reg | {4{force_conn_i}}) & used; // RL16

    always_comb
    begin
        // Detection wins over a clear in the same cycle
        conn_next = ((conn_clear_i ? 4'h0 : conn_reg) | conn_i) & used; // RL11
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            conn_reg <= 4'h0;
        else
            conn_reg <= conn_next;
    end
endmodule // wbcsr_lanes

// *** wbcsr_top.sv ***
// Wishbone slave into the endpoint configuration space and link CSRs.
// Assumes a config-space array port with a link-side arbitration busy flag.
`timescale 1ns/1ps
module wbcsr_top
    import wbcsr_pkg::*;
#(
    parameter int LANES = 1,
    parameter logic [31:0] TIMER_RST = WBCSR_TIMER_RST,
    parameter logic [31:0] UPD_POST_RST = WBCSR_UPD_RST,
    parameter logic [31:0] UPD_NPOST_RST = WBCSR_UPD_RST,
    parameter logic [31:0] UPD_CPL_RST = WBCSR_UPD_RST,
    parameter logic [31:0] FCT_RST = WBCSR_FCT_RST
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [12:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Configuration space port
    input wire logic cfg_link_busy_i,
    input wire logic [31:0] cfg_rdata_i,
    output logic cfg_req_o,
    output logic cfg_we_o,
    output logic [9:0] cfg_addr_o,
    output logic [31:0] cfg_wdata_o,
    output logic [3:0] cfg_be_o,
    // Link layer
    input wire wbcsr_rx_dllp_s rx_dllp_i,
    input wire logic tx_vend_sent_i,
    input wire logic tx_pwr_sent_i,
    output logic tx_vend_req_o,
    output logic tx_pwr_req_o,
    output logic [23:0] tx_vend_data_o,
    output logic [2:0] tx_pwr_type_o,
    input wire wbcsr_phy_stat_s phy_stat_i,
    output wbcsr_ctrl_s ctrl_o,
    output logic [31:0] timers_o,
    output logic [17:0] upd_post_o,
    output logic [17:0] upd_npost_o,
    output logic [17:0] upd_cpl_o,
    output logic [11:0] fc_timer_o,
    output logic [7:0] link_num_o
);
    // ----------------------------------------
    // Bus state
    // ----------------------------------------
    wbcsr_state_e state_reg, state_next;
    logic [31:0] rdat_reg, rdat_next;
    logic ack_next;
    logic req_reg, req_next;
    logic is_cfg;
    logic wr_hit;
    logic [31:0] wmask;
    logic [31:0] wdata;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [31:0] rx_reg, rx_next;
    logic [31:0] tx_reg, tx_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] tim_reg, tim_next;
    logic [31:0] upp_reg, upp_next;
    logic [31:0] upn_reg, upn_next;
    logic [31:0] upc_reg, upc_next;
    logic [31:0] fct_reg, fct_next;
    logic [31:0] lnum_reg, lnum_next;
    logic [31:0] csr_rd;
    logic [3:0] sync_eff, idle_eff, conn_eff;
    logic conn_clear;

    // Lanes already arrive in write order, 7:0 per lane; no swap on writes
    assign wdata = wb_dat_i; // RL1 RL4
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign is_cfg = (wb_adr_i <= WBCSR_CFG_LAST); // RL5
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !is_cfg;
    assign conn_clear = wr_hit && (wb_adr_i == WBCSR_STATUS); // RL11

    wbcsr_lanes #(
        .LANES(LANES)
    ) u_lanes (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .force_sync_i(ctrl_reg[15]),
        .force_idle_i(ctrl_reg[14]),
        .force_conn_i(ctrl_reg[13]),
        .conn_clear_i(conn_clear),
        .sync_i(phy_stat_i.lane_sync_state),
        .idle_i(phy_stat_i.rx_elec_idle),
        .conn_i(phy_stat_i.conn_set),
        .sync_o(sync_eff),
        .idle_o(idle_eff),
        .conn_o(conn_eff)
    );

    // ----------------------------------------
    // CSR read mux
    // ----------------------------------------
    always_comb
    begin
        csr_rd = 32'h00000000; // RL22
        case (wb_adr_i)
            WBCSR_RX_DLLP: csr_rd = rx_reg;
            WBCSR_TX_DLLP: csr_rd = tx_reg;
            WBCSR_STATUS: csr_rd = {8'h00, sync_eff, conn_eff, idle_eff, // RL10 RL11 RL12
                phy_stat_i.ltssm_state, phy_stat_i.dl_state, 3'h0}; // RL13 RL14
            WBCSR_CONTROL: csr_rd = ctrl_reg;
            WBCSR_TIMERS: csr_rd = tim_reg;
            WBCSR_UPD_POST: csr_rd = upp_reg;
            WBCSR_UPD_NPOST: csr_rd = upn_reg;
            WBCSR_UPD_CPL: csr_rd = upc_reg;
            WBCSR_FC_TIMER: csr_rd = fct_reg;
            WBCSR_LINK_NUM: csr_rd = lnum_reg;
            default: csr_rd = 32'h00000000;
        endcase
    end

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        rdat_next = rdat_reg;
        ack_next = 1'b0;
        req_next = 1'b0;
        case (state_reg)
            WBCSR_IDLE:
            begin
                if (wb_cyc_i && wb_stb_i)
                begin
                    if (is_cfg)
                    begin
                        // Link access owns the array; hold off the ack
                        if (!cfg_link_busy_i) // RL21
                        begin
                            req_next = 1'b1;
                            state_next = WBCSR_WAIT;
                        end
                    end
                    else
                    begin
                        rdat_next = csr_rd; // RL3
                        ack_next = 1'b1;
                        state_next = WBCSR_ACK;
                    end
                end
            end
            WBCSR_WAIT:
            begin
                // Read data valid in the same cycle as the request
                rdat_next = wbcsr_swap(cfg_rdata_i); // RL2
                ack_next = 1'b1;
                state_next = WBCSR_ACK;
            end
            WBCSR_ACK:
                state_next = WBCSR_IDLE;
            default:
                state_next = WBCSR_IDLE;
        endcase
    end

    // ----------------------------------------
    // Register updates
    // ----------------------------------------
    function automatic logic [31:0] wbcsr_upd(input logic [31:0] cur, input logic [31:0] m);
        wbcsr_upd = ((cur & ~(wmask & m)) | (wdata & wmask & m)); // RL22
    endfunction

    always_comb
    begin
        rx_next = rx_reg;
        tx_next = tx_reg;
        ctrl_next = ctrl_reg;
        tim_next = tim_reg;
        upp_next = upp_reg;
        upn_next = upn_reg;
        upc_next = upc_reg;
        fct_next = fct_reg;
        lnum_next = lnum_reg;
        if (wr_hit)
        begin
            case (wb_adr_i)
                WBCSR_RX_DLLP: rx_next = 32'h00000000; // RL6
                WBCSR_TX_DLLP: tx_next = wbcsr_upd(tx_reg, WBCSR_TX_MASK); // RL8
                WBCSR_CONTROL: ctrl_next = wbcsr_upd(ctrl_reg, WBCSR_CTRL_MASK); // RL18
                WBCSR_TIMERS: tim_next = wbcsr_upd(tim_reg, WBCSR_TIMER_MASK);
                WBCSR_UPD_POST: upp_next = wbcsr_upd(upp_reg, WBCSR_UPD_MASK); // RL20
                WBCSR_UPD_NPOST: upn_next = wbcsr_upd(upn_reg, WBCSR_UPD_MASK); // RL20
                WBCSR_UPD_CPL: upc_next = wbcsr_upd(upc_reg, WBCSR_UPD_MASK); // RL20
                WBCSR_FC_TIMER: fct_next = wbcsr_upd(fct_reg, WBCSR_FCT_MASK);
                WBCSR_LINK_NUM: lnum_next = wbcsr_upd(lnum_reg, WBCSR_LNUM_MASK);
                default: rx_next = rx_reg;
            endcase
        end
        // Events win over a clear in the same cycle
        if (rx_dllp_i.vend_valid)
        begin
            rx_next[WBCSR_RX_VEND_BIT] = 1'b1; // RL6
            rx_next[28:3] = rx_dllp_i.vend_data; // RL7
        end
        if (rx_dllp_i.pwr_valid)
        begin
            rx_next[WBCSR_RX_PWR_BIT] = 1'b1; // RL6
            rx_next[2:0] = rx_dllp_i.pwr_type; // RL7
        end
        if (tx_vend_sent_i)
            tx_next[WBCSR_TX_VEND_BIT] = 1'b0; // RL8
        if (tx_pwr_sent_i)
            tx_next[WBCSR_TX_PWR_BIT] = 1'b0; // RL8
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= WBCSR_IDLE;
            rdat_reg <= 32'h00000000;
            wb_ack_o <= 1'b0;
            req_reg <= 1'b0;
            rx_reg <= WBCSR_ZERO_RST;
            tx_reg <= WBCSR_ZERO_RST;
            ctrl_reg <= WBCSR_ZERO_RST; // RL23
            tim_reg <= TIMER_RST;
            upp_reg <= UPD_POST_RST;
            upn_reg <= UPD_NPOST_RST;
            upc_reg <= UPD_CPL_RST;
            fct_reg <= FCT_RST;
            lnum_reg <= WBCSR_ZERO_RST;
        end
        else
        begin
            state_reg <= state_next;
            rdat_reg <= rdat_next;
            wb_ack_o <= ack_next;
            req_reg <= req_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            ctrl_reg <= ctrl_next;
            tim_reg <= tim_next;
            upp_reg <= upp_next;
            upn_reg <= upn_next;
            upc_reg <= upc_next;
            fct_reg <= fct_next;
            lnum_reg <= lnum_next;
        end
    end

    // ----------------------------------------
    // Config-space request and outputs
    // ----------------------------------------
    logic cfg_we_reg;
    logic [9:0] cfg_addr_reg;
    logic [31:0] cfg_wdata_reg;
    logic [3:0] cfg_be_reg;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cfg_we_reg <= 1'b0;
            cfg_addr_reg <= 10'h000;
            cfg_wdata_reg <= 32'h00000000;
            cfg_be_reg <= 4'h0;
        end
        else if (req_next)
        begin
            cfg_we_reg <= wb_we_i;
            cfg_addr_reg <= wb_adr_i[11:2]; // RL5
            cfg_wdata_reg <= wdata; // RL1
            cfg_be_reg <= wb_sel_i;
        end
    end

    assign wb_dat_o = rdat_reg;
    assign cfg_req_o = req_reg;
    assign cfg_we_o = cfg_we_reg;
    assign cfg_addr_o = cfg_addr_reg;
    assign cfg_wdata_o = cfg_wdata_reg;
    assign cfg_be_o = cfg_be_reg;
    assign tx_vend_req_o = tx_reg[WBCSR_TX_VEND_BIT]; // RL8
    assign tx_pwr_req_o = tx_reg[WBCSR_TX_PWR_BIT];
    assign tx_vend_data_o = tx_reg[26:3]; // RL9
    assign tx_pwr_type_o = tx_reg[2:0]; // RL9
    assign ctrl_o = ctrl_reg[21:0]; // RL15 RL16 RL17 RL19
    assign timers_o = tim_reg;
    assign upd_post_o = upp_reg[17:0];
    assign upd_npost_o = upn_reg[17:0];
    assign upd_cpl_o = upc_reg[17:0];
    assign fc_timer_o = fct_reg[11:0];
    assign link_num_o = lnum_reg[7:0];
endmodule // wbcsr_top

// *** wbcsr_top_chk_assertions.sv ***
// Concurrent checks on the Wishbone CSR port: handshake timing, config path, CSR side effects.
// Assumes a master that drops strobe for at least one cycle between transfers.
`timescale 1ns/1ps
module wbcsr_top_chk
    import wbcsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [12:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Config port and link
    input wire logic cfg_link_busy_i,
    input wire logic [31:0] cfg_rdata_i,
    input wire logic cfg_req_o,
    input wire logic cfg_we_o,
    input wire logic [9:0] cfg_addr_o,
    input wire logic [31:0] cfg_wdata_o,
    input wire logic tx_vend_sent_i,
    input wire logic tx_vend_req_o,
    input wire wbcsr_ctrl_s ctrl_o
);
    logic [31:0] swap_reg;
    logic [31:0] swap_next;
    default clocking dck @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // Swap kept apart from the design so a lane slip cannot hide in both
    always_comb
    begin
        swap_next = {cfg_rdata_i[7:0], cfg_rdata_i[15:8], cfg_rdata_i[23:16], cfg_rdata_i[31:24]};
    end
    always_ff @(posedge clk_sys_i)
    begin
        swap_reg <= swap_next;
    end
    // ------------------------------------------------------------
    // Handshake and data paths
    // ------------------------------------------------------------
    sequence s_take;
        $rose(wb_stb_i) && wb_cyc_i;
    endsequence
    sequence s_cfg_done;
        cfg_req_o ##1 wb_ack_o;
    endsequence
    property p_csr_ack;
        s_take ##0 wb_adr_i[12] |=> wb_ack_o;
    endproperty
    a_csr_ack: assert property (p_csr_ack) else $error("CSR access not acked");
    property p_cfg_path;
        s_take ##0 (!wb_adr_i[12] && !cfg_link_busy_i) |=> s_cfg_done;
    endproperty
    a_cfg_path: assert property (p_cfg_path) else $error("config access timing wrong");
    property p_cfg_addr;
        s_take ##0 (!wb_adr_i[12] && !cfg_link_busy_i) |=> cfg_addr_o == $past(wb_adr_i[11:2])
            && cfg_we_o == $past(wb_we_i) && (!cfg_we_o || cfg_wdata_o == $past(wb_dat_i));
    endproperty
    a_cfg_addr: assert property (p_cfg_addr) else $error("config request fields wrong");
    property p_cfg_swap;
        cfg_req_o && !cfg_we_o |=> wb_dat_o == swap_reg;
    endproperty
    a_cfg_swap: assert property (p_cfg_swap) else $error("config read lanes wrong");
    property p_cfg_wait;
        wb_cyc_i && wb_stb_i && !wb_adr_i[12] && cfg_link_busy_i && !cfg_req_o && !wb_ack_o
            |=> !cfg_req_o && !wb_ack_o;
    endproperty
    a_cfg_wait: assert property (p_cfg_wait) else $error("config access during link access");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_tx_clear;
        tx_vend_sent_i && !wb_stb_i |=> !tx_vend_req_o;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("vendor request not cleared");
    property p_ctrl_hold;
        !(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(ctrl_o);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");
    property p_ctrl_write;
        s_take ##0 (wb_we_i && wb_sel_i == 4'hF && wb_adr_i == WBCSR_CONTROL)
            |=> ctrl_o == ($past(wb_dat_i[21:0]) & 22'h3FFFF7);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");
endmodule // wbcsr_top_chk

bind wbcsr_top wbcsr_top_chk u_wbcsr_top_chk (.*);

// *** wbcsr_wb_master.sv ***
// Wishbone master standing in for user logic; one transfer at a time.
// Assumes each transfer is started just after a rising clock edge.
`timescale 1ns/1ps
module wbcsr_wb_master
(
    // Clock
    input wire logic clk_sys_i,
    // Request
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [12:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    // Answer
    input wire logic [31:0] rdat_i,
    input wire logic ack_i
);
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 13'h0000;
        sel_o = 4'hF;
        dat_o = 32'h00000000;
    end
    // ------------------------------------------------------------
    // Transfer: hold everything until ack is seen at a rising edge
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d,
                        output logic [31:0] q, output int n);
        n = 0;
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        @(posedge clk_sys_i);
        while (ack_i !== 1'b1 && n < 40)
        begin
            n++;
            @(posedge clk_sys_i);
        end
        q = rdat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Released lines carry garbage, not the last value
        adr_o <= ~a;
        dat_o <= ~d;
        @(posedge clk_sys_i);
    endtask
endmodule // wbcsr_wb_master

// *** wbcsr_top_tb_top.sv ***
// Self-checking bench for the Wishbone CSR port with config-space and link models.
// Assumes the hand-over timing of the design; LANES stays at 1.
`timescale 1ns/1ps
module wbcsr_top_tb_top;
    import wbcsr_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic cfg_link_busy_i = 1'b0;
    logic tx_vend_sent_i = 1'b0;
    logic tx_pwr_sent_i = 1'b0;
    wbcsr_rx_dllp_s rx_dllp_i = '0;
    wbcsr_phy_stat_s phy_stat_i = '0;
    wbcsr_phy_stat_s s;
    wbcsr_ctrl_s ctrl_o;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cfg_req_o, cfg_we_o, tx_vend_req_o, tx_pwr_req_o;
    logic cs;
    logic [12:0] wb_adr_i, a;
    logic [3:0] wb_sel_i, cfg_be_o;
    logic [31:0] wb_dat_i, wb_dat_o, cfg_rdata_i, cfg_wdata_o, timers_o, d, rq, rnd;
    logic [9:0] cfg_addr_o;
    logic [23:0] tx_vend_data_o;
    logic [2:0] tx_pwr_type_o;
    logic [17:0] upd_post_o, upd_npost_o, upd_cpl_o;
    logic [11:0] fc_timer_o;
    logic [7:0] link_num_o;
    logic [31:0] cfg_mem [1024];
    logic [31:0] wv [7];
    logic [12:0] adr_t [7] = '{WBCSR_CONTROL, WBCSR_TIMERS, WBCSR_UPD_POST, WBCSR_UPD_NPOST,
        WBCSR_UPD_CPL, WBCSR_FC_TIMER, WBCSR_LINK_NUM};
    logic [31:0] msk_t [7] = '{WBCSR_CTRL_MASK, WBCSR_TIMER_MASK, WBCSR_UPD_MASK, WBCSR_UPD_MASK,
        WBCSR_UPD_MASK, WBCSR_FCT_MASK, WBCSR_LNUM_MASK};
    logic [12:0] qa [$];
    logic [31:0] qd [$];
    int num_errors = 0;
    int total_checks = 0;
    int lat;

    always #12.5 clk_sys_i = ~clk_sys_i;

    wbcsr_top u_wbcsr_top (.*);
    wbcsr_wb_master u_wbcsr_wb_master (.clk_sys_i, .cyc_o(wb_cyc_i), .stb_o(wb_stb_i),
        .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i),
        .rdat_i(wb_dat_o), .ack_i(wb_ack_o));

    // Config space behind the port: combinational read, byte-enabled write
    assign cfg_rdata_i = cfg_mem[cfg_addr_o];
    always @(posedge clk_sys_i)
    begin
        if (cfg_req_o === 1'b1 && cfg_we_o === 1'b1)
            for (int b = 0; b < 4; b++)
                if (cfg_be_o[b])
                    cfg_mem[cfg_addr_o][8*b +: 8] <= cfg_wdata_o[8*b +: 8];
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] bswap(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [12:0] ad, input logic [31:0] wd);
        u_wbcsr_wb_master.xfer(w, ad, wd, rq, lat);
        if (lat >= 40)
        begin
            num_errors++;
            final_report();
        end
    endtask
    task automatic rdchk(input logic [12:0] ad, input logic [31:0] exp);
        acc(1'b0, ad, 32'h00000000);
        chk(rq, exp);
    endtask
    task automatic pulse_sent(input logic v, input logic p);
        tx_vend_sent_i <= v;
        tx_pwr_sent_i <= p;
        @(posedge clk_sys_i);
        tx_vend_sent_i <= 1'b0;
        tx_pwr_sent_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    initial
    begin
        rnd = $urandom(32'h82BF6BBF);
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        for (int i = 0; i < 13; i++)
            rdchk(13'h1000 + 13'(4 * i), 32'h00000000);
        for (int i = 0; i < 7; i++)
        begin
            // Upper loopback lanes do not exist in a single-lane build
            d = $urandom & (i == 0 ? 32'hFFC7FFFF : 32'hFFFFFFFF);
            wv[i] = d & msk_t[i];
            acc(1'b1, adr_t[i], d);
            rdchk(adr_t[i], wv[i]);
        end
        acc(1'b1, 13'h1030, 32'hFFFFFFFF);
        rdchk(13'h1030, 32'h00000000);
        chk({10'h000, ctrl_o}, wv[0]);
        chk(timers_o, wv[1]);
        chk({14'h0000, upd_cpl_o}, wv[4]);
        chk({24'h000000, link_num_o}, wv[6]);
        chk({14'h0000, upd_post_o}, wv[2]);
        chk({14'h0000, upd_npost_o}, wv[3]);
        chk({20'h00000, fc_timer_o}, wv[5]);
        acc(1'b1, WBCSR_CONTROL, 32'h00000000);
        cs = 1'b0;
        for (int c = 0; c < 11; c++)
        begin
            s = 21'($urandom);
            s.ltssm_state = 5'(c);
            phy_stat_i <= s;
            cs = cs | s.conn_set[0];
            repeat (2) @(posedge clk_sys_i);
            d = {11'h000, s.lane_sync_state[0], 3'h0, cs, 3'h0, s.rx_elec_idle[0],
                s.ltssm_state, s.dl_state, 3'h0};
            rdchk(WBCSR_STATUS, d);
        end
        phy_stat_i <= '0;
        repeat (2) @(posedge clk_sys_i);
        acc(1'b1, WBCSR_STATUS, 32'h00000000);
        rdchk(WBCSR_STATUS, 32'h00000000);
        acc(1'b1, WBCSR_CONTROL, 32'h0000E000);
        rdchk(WBCSR_STATUS, 32'h00111000);
        acc(1'b1, WBCSR_CONTROL, 32'h00000000);
        acc(1'b1, WBCSR_STATUS, 32'h00000000);
        rnd = $urandom;
        rx_dllp_i <= {1'b1, rnd[25:0], 1'b1, rnd[28:26]};
        @(posedge clk_sys_i);
        rx_dllp_i <= '0;
        @(posedge clk_sys_i);
        rdchk(WBCSR_RX_DLLP, {3'b110, rnd[25:0], rnd[28:26]});
        acc(1'b1, WBCSR_RX_DLLP, 32'h00000000);
        rdchk(WBCSR_RX_DLLP, 32'h00000000);
        d = $urandom | 32'hC0000000;
        acc(1'b1, WBCSR_TX_DLLP, d);
        chk({6'h00, tx_vend_req_o, tx_pwr_req_o, tx_vend_data_o}, {6'h00, 2'b11, d[26:3]});
        chk({29'h0, tx_pwr_type_o}, {29'h0, d[2:0]});
        pulse_sent(1'b1, 1'b0);
        rdchk(WBCSR_TX_DLLP, d & 32'h47FFFFFF);
        pulse_sent(1'b0, 1'b1);
        rdchk(WBCSR_TX_DLLP, d & 32'h07FFFFFF);
        for (int i = 0; i < 6; i++)
        begin
            a = 13'(i * 680 + 4 * $urandom_range(15));
            d = $urandom;
            acc(1'b1, a, d);
            chk(32'(lat), 32'd2);
            chk(cfg_mem[a[11:2]], d);
            qa.push_back(a);
            qd.push_back(d);
        end
        while (qa.size() > 0)
            rdchk(qa.pop_front(), bswap(qd.pop_front()));
        cfg_link_busy_i <= 1'b1;
        @(posedge clk_sys_i);
        fork
            acc(1'b0, a, 32'h00000000);
            begin
                repeat (4) @(posedge clk_sys_i);
                cfg_link_busy_i <= 1'b0;
            end
        join
        chk(32'(lat), 32'd6);
        chk(rq, bswap(d));
        final_report();
    end
endmodule // wbcsr_top_tb_top
